//--- src/dmd_consts.svh
/*
 * Constants for the data memory space decoder: address limits, sizes,
 * external bus cycle timing and reset values.
 * Assumes inclusion by bare name from the decoder sources.
 */
`ifndef DMD_CONSTS_SVH
`define DMD_CONSTS_SVH

`define DMD_LOWER_RAM_TOP 8'h7F
`define DMD_XRAM_SIZE_DEF 768
`define DMD_XRAM_AW 10
`define DMD_BYPASS_RESET 1'b0
`define DMD_EXT_ALE_CYC 4'h2
`define DMD_EXT_STROBE_CYC 4'h6
`define DMD_EXT_HOLD_CYC 4'h1

`endif

//--- src/dmd_pkg.sv
/*
 * Types for the data memory space decoder.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dmd_pkg;
	typedef enum logic [1:0] {
		DMD_SPACE_LOWER = 2'b00,
		DMD_SPACE_UPPER = 2'b01,
		DMD_SPACE_SFR = 2'b10
	} dmd_space_t;
	typedef enum logic [1:0] {
		DMD_ST_IDLE = 2'b00,
		DMD_ST_ADDR = 2'b01,
		DMD_ST_STROBE = 2'b10,
		DMD_ST_HOLD = 2'b11
	} dmd_state_t;
endpackage

//--- src/dmd_xram.sv
/*
 * On-chip expanded data RAM, synchronous read and write.
 * Assumes one clock; read data is valid the cycle after the request.
 */
`timescale 1ns/100ps
`default_nettype none
module dmd_xram #(
	parameter int DEPTH = 768,
	parameter int AW = 10
) (
	// Clock
	input wire logic mclk,
	// Access
	input wire logic en,
	input wire logic wr,
	input wire logic [AW-1:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:DEPTH-1];

	// Storage and registered read
	always_ff @(posedge mclk) begin
		if (en) begin
			if (wr) begin
				mem[addr] <= wdata;
			end
			rdata <= mem[addr];
		end
	end
endmodule // dmd_xram
`default_nettype wire

//--- src/dmd_decoder.sv
/*
 * Data memory space decoder: internal RAM and SPECIAL_FUNCTION_REGISTER space selection,
 * stack placement, and external-move routing to on-chip expanded RAM
 * or the multiplexed external bus on port zero and port two.
 * Assumes the core holds an access request steady until done.
 */
// Operation
// R1: Lower RAM 00H-7FH is reachable by direct and indirect addressing.
// R2: Upper RAM 80H-FFH is reachable only indirectly and is separate from SFRs.
// R3: Above 7FH, direct addressing selects SPECIAL_FUNCTION_REGISTER space and indirect selects upper RAM.
// R4: A 256/768-byte on-chip expanded RAM is reached only by indirect external moves with bypass clear.
// R5: With bypass clear, expanded RAM is addressed by a bank index register or the data pointer.
// R6: Expanded RAM accesses leave port zero and both strobes untouched.
// R7: Port two keeps its register contents during external cycles not using the pointer high byte.
// R8: With bypass clear, pointer moves above the on-chip range run as standard external cycles.
// R9: With bypass set, an indexed move puts an 8-bit address multiplexed with data on port zero.
// R10: With bypass set, a pointer move drives the high byte on port two and low byte on port zero.
// R11: External cycles assert write strobe for stores and read strobe for loads.
// R12: The stack covers all 256 internal RAM bytes and never the expanded RAM.
// R13: The bypass bit resets to 0 so expanded RAM is selected after reset.
`timescale 1ns/100ps
`default_nettype none
`include "dmd_consts.svh"
module dmd_decoder import dmd_pkg::*; #(
	parameter int XRAM_SIZE = `DMD_XRAM_SIZE_DEF,
	parameter int XRAM_AW = `DMD_XRAM_AW
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Internal data access from the core
	input wire logic int_req,
	input wire logic int_direct,
	input wire logic int_stack,
	input wire logic [7:0] int_addr,
	input wire logic [7:0] stack_pointer,
	output logic sel_lower_q,
	output logic sel_upper_q,
	output logic sel_sfr_q,
	output logic [7:0] int_ram_addr_q,
	// Auxiliary control bit
	input wire logic bypass_wr,
	input wire logic bypass_wdata,
	output logic onchip_xram_bypass_q,
	// External move request
	input wire logic xm_req,
	input wire logic xm_write,
	input wire logic xm_use_data_pointer,
	input wire logic [7:0] bank_index_register,
	input wire logic [7:0] data_pointer_high,
	input wire logic [7:0] data_pointer_low,
	input wire logic [7:0] xm_wdata,
	output logic xm_done_q,
	output logic [7:0] xm_rdata_q,
	// Port register values from SPECIAL_FUNCTION_REGISTER space
	input wire logic [7:0] port_zero_sfr,
	input wire logic [7:0] port_two_sfr,
	// External bus pins
	input wire logic [7:0] port_zero_in,
	output logic [7:0] port_zero_bus_q,
	output logic port_zero_oe_q,
	output logic [7:0] port_two_upper_address_q,
	output logic ale_q,
	output logic wr_n_q,
	output logic rd_n_q
);
	dmd_state_t state_q;
	logic [3:0] cnt_q;
	logic [7:0] pz_sync1_q;
	logic [7:0] pz_sync2_q;
	logic [15:0] xaddr;
	logic xram_hit;
	logic xram_busy_q;
	logic [7:0] xram_rdata;
	logic [7:0] int_eff_addr;
	logic int_is_high;

	// Pick a space for an internal address and addressing mode
	function automatic dmd_space_t space_of(input logic [7:0] a, input logic direct);
		if (a <= `DMD_LOWER_RAM_TOP) begin
			space_of = DMD_SPACE_LOWER; // R1
		end else if (direct) begin
			space_of = DMD_SPACE_SFR; // R3
		end else begin
			space_of = DMD_SPACE_UPPER; // R2 R3
		end
	endfunction

	// Stack uses the pointer and is always indirect internal RAM
	assign int_eff_addr = int_stack ? stack_pointer : int_addr; // R12
	assign int_is_high = int_eff_addr > `DMD_LOWER_RAM_TOP;

	// Internal space select, registered
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sel_lower_q <= 1'b0;
			sel_upper_q <= 1'b0;
			sel_sfr_q <= 1'b0;
			int_ram_addr_q <= 8'h00;
		end else begin
			sel_lower_q <= int_req && !int_is_high;
			sel_upper_q <= int_req && int_is_high && (int_stack || !int_direct); // R2 R12
			sel_sfr_q <= int_req && !int_stack &&
				(space_of(int_eff_addr, int_direct) == DMD_SPACE_SFR); // R3
			int_ram_addr_q <= int_eff_addr;
		end
	end

	// Expanded RAM control bit
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			onchip_xram_bypass_q <= `DMD_BYPASS_RESET; // R13
		end else if (bypass_wr) begin
			onchip_xram_bypass_q <= bypass_wdata;
		end
	end

	// External-move address source
	assign xaddr = xm_use_data_pointer ? {data_pointer_high, data_pointer_low}
		: {8'h00, bank_index_register}; // R5
	assign xram_hit = !onchip_xram_bypass_q && (xaddr < 16'(XRAM_SIZE)); // R4 R8

	// On-chip expanded RAM, no stack path into it
	dmd_xram #(
		.DEPTH(XRAM_SIZE),
		.AW(XRAM_AW)
	) u_xram (
		.mclk(mclk),
		.en(xm_req && xram_hit && state_q == DMD_ST_IDLE && !xram_busy_q && !xm_done_q), // R4
		.wr(xm_write),
		.addr(xaddr[XRAM_AW-1:0]),
		.wdata(xm_wdata),
		.rdata(xram_rdata)
	);

	// Synchronise port zero pin inputs
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pz_sync1_q <= 8'h00;
			pz_sync2_q <= 8'h00;
		end else begin
			pz_sync1_q <= port_zero_in;
			pz_sync2_q <= pz_sync1_q;
		end
	end

	// External cycle sequencer and expanded RAM completion
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_q <= DMD_ST_IDLE;
			cnt_q <= 4'h0;
			xram_busy_q <= 1'b0;
			xm_done_q <= 1'b0;
			xm_rdata_q <= 8'h00;
		end else begin
			xm_done_q <= 1'b0;
			case (state_q)
				DMD_ST_IDLE: begin
					if (xram_busy_q) begin
						xram_busy_q <= 1'b0;
						xm_done_q <= 1'b1;
						xm_rdata_q <= xram_rdata; // R6
					end else if (xm_req && !xm_done_q) begin
						if (xram_hit) begin
							xram_busy_q <= 1'b1;
						end else begin
							state_q <= DMD_ST_ADDR; // R8 R9 R10
							cnt_q <= `DMD_EXT_ALE_CYC;
						end
					end
				end
				DMD_ST_ADDR: begin
					if (cnt_q == 4'h1) begin
						state_q <= DMD_ST_STROBE;
						cnt_q <= `DMD_EXT_STROBE_CYC;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				DMD_ST_STROBE: begin
					if (cnt_q == 4'h1) begin
						state_q <= DMD_ST_HOLD;
						cnt_q <= `DMD_EXT_HOLD_CYC;
						if (!xm_write) begin
							xm_rdata_q <= pz_sync2_q;
						end
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				DMD_ST_HOLD: begin
					state_q <= DMD_ST_IDLE;
					xm_done_q <= 1'b1;
				end
				default: begin
					state_q <= DMD_ST_IDLE;
				end
			endcase
		end
	end

	// Port zero: address then write data; idle shows its register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			port_zero_bus_q <= 8'hFF;
			port_zero_oe_q <= 1'b0;
		end else begin
			case (state_q)
				DMD_ST_IDLE: begin
					port_zero_bus_q <= xaddr[7:0]; // R9 R10
					port_zero_oe_q <= xm_req && !xram_hit && !xram_busy_q && !xm_done_q;
					if (!(xm_req && !xram_hit && !xram_busy_q && !xm_done_q)) begin
						port_zero_bus_q <= port_zero_sfr; // R6
						port_zero_oe_q <= 1'b0;
					end
				end
				DMD_ST_ADDR: begin
					port_zero_oe_q <= (cnt_q == 4'h1) ? xm_write : 1'b1;
					if (cnt_q == 4'h1) begin
						port_zero_bus_q <= xm_wdata;
					end
				end
				DMD_ST_STROBE: begin
					port_zero_oe_q <= xm_write;
				end
				default: begin
					port_zero_oe_q <= 1'b0;
					port_zero_bus_q <= port_zero_sfr;
				end
			endcase
		end
	end

	// Port two: pointer high byte only for pointer moves
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			port_two_upper_address_q <= 8'hFF;
		end else if (state_q != DMD_ST_IDLE && xm_use_data_pointer) begin
			port_two_upper_address_q <= data_pointer_high; // R10
		end else if (state_q == DMD_ST_IDLE && xm_req && !xram_hit && xm_use_data_pointer
			&& !xram_busy_q && !xm_done_q) begin
			port_two_upper_address_q <= data_pointer_high; // R10
		end else begin
			port_two_upper_address_q <= port_two_sfr; // R7
		end
	end

	// Address latch enable and strobes
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ale_q <= 1'b0;
			wr_n_q <= 1'b1;
			rd_n_q <= 1'b1;
		end else begin
			ale_q <= state_q == DMD_ST_IDLE && xm_req && !xram_hit && !xram_busy_q && !xm_done_q;
			if (state_q == DMD_ST_ADDR && cnt_q == 4'h1) begin
				wr_n_q <= !xm_write; // R11
				rd_n_q <= xm_write; // R11
			end else if (state_q != DMD_ST_STROBE || cnt_q == 4'h1) begin
				wr_n_q <= 1'b1; // R6
				rd_n_q <= 1'b1; // R6
			end
		end
	end
endmodule // dmd_decoder
`default_nettype wire

//--- tb/dmd_properties.sv
/* Decoder port checker with its bind.
   Assumes the ports of dmd_decoder. */
`timescale 1ns/100ps
`default_nettype none
module dmd_checker (
	// Clock, reset, core side
	input wire logic mclk, rst, int_req, int_direct, int_stack,
	input wire logic [7:0] int_addr, stack_pointer, int_ram_addr_q,
	input wire logic sel_lower_q, sel_upper_q, sel_sfr_q, onchip_xram_bypass_q,
	// External move side
	input wire logic xm_req, xm_write, xm_use_data_pointer, xm_done_q,
	input wire logic [7:0] bank_index_register, data_pointer_high, data_pointer_low,
	// Pins
	input wire logic [7:0] port_two_sfr, port_zero_bus_q, port_two_upper_address_q,
	input wire logic port_zero_oe_q, ale_q, wr_n_q, rd_n_q
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// Space selection and stack placement
	lower_select_a: assert property (int_req && !int_stack && int_addr <= 8'h7F |=> sel_lower_q && !sel_sfr_q) else $error("lower select wrong");
	sfr_select_a: assert property (int_req && !int_stack && int_direct && int_addr > 8'h7F |=> sel_sfr_q && !sel_upper_q) else $error("sfr select wrong");
	upper_select_a: assert property (int_req && !int_stack && !int_direct && int_addr > 8'h7F |=> sel_upper_q && int_ram_addr_q == $past(int_addr)) else $error("upper select wrong");
	stack_ram_a: assert property (int_req && int_stack |=> !sel_sfr_q && int_ram_addr_q == $past(stack_pointer)) else $error("stack placement wrong");
	// Bus behaviour
	xram_quiet_a: assert property (xm_req && !onchip_xram_bypass_q && !xm_use_data_pointer |-> wr_n_q && rd_n_q && !port_zero_oe_q) else $error("pins moved on xram access");
	addr_phase_a: assert property (ale_q |-> port_zero_oe_q && port_zero_bus_q == (xm_use_data_pointer ? data_pointer_low : bank_index_register) && port_two_upper_address_q == (xm_use_data_pointer ? data_pointer_high : port_two_sfr)) else $error("address phase wrong");
	write_strobe_a: assert property ($fell(wr_n_q) |-> (xm_write && rd_n_q) ##0 (!wr_n_q)[*6] ##1 wr_n_q) else $error("write strobe wrong");
	read_strobe_a: assert property ($fell(rd_n_q) |-> (!xm_write && wr_n_q) ##0 (!rd_n_q)[*6] ##2 xm_done_q) else $error("read strobe wrong");
	ext_done_a: assert property ($rose(ale_q) |-> ##9 xm_done_q) else $error("external cycle length wrong");
	// Main scenarios
	cover property (sel_sfr_q);
	cover property (!rd_n_q && onchip_xram_bypass_q);
	cover property (xm_done_q && !onchip_xram_bypass_q);
endmodule // dmd_checker
bind dmd_decoder dmd_checker i_chk (.mclk, .rst, .int_req, .int_direct, .int_stack, .int_addr,
	.stack_pointer, .int_ram_addr_q, .sel_lower_q, .sel_upper_q, .sel_sfr_q,
	.onchip_xram_bypass_q, .xm_req, .xm_write, .xm_use_data_pointer, .xm_done_q, .bank_index_register,
	.data_pointer_high, .data_pointer_low, .port_two_sfr, .port_zero_bus_q,
	.port_two_upper_address_q, .port_zero_oe_q, .ale_q, .wr_n_q, .rd_n_q);
`default_nettype wire

//--- tb/dmd_ext_mem.sv
/* External data memory on the multiplexed bus.
   Assumes decoder pin timing, one clock. */
`timescale 1ns/100ps
`default_nettype none
module dmd_ext_mem (
	// Bus from the decoder
	input wire logic mclk, ale_q, wr_n_q, rd_n_q,
	input wire logic [7:0] port_zero_bus_q, port_two_upper_address_q,
	// Data back
	output logic [7:0] port_zero_in
);
	logic [7:0] mem [logic [15:0]];
	logic [15:0] addr_q = 16'h0000;
	initial port_zero_in = 8'h00;
	// Latch address, store on write, answer on read, else toggle
	always @(posedge mclk) begin
		if (ale_q) addr_q <= {port_two_upper_address_q, port_zero_bus_q};
		if (!wr_n_q) mem[addr_q] = port_zero_bus_q;
		if (!rd_n_q && mem.exists(addr_q)) port_zero_in <= mem[addr_q];
		else port_zero_in <= ~port_zero_in; // Released bus
	end
endmodule // dmd_ext_mem
`default_nettype wire

//--- tb/tb_top.sv
/* Self-checking bench for the decoder.
   Assumes dmd_ext_mem on the pins. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic mclk = 1'b0, rst = 1'b1, int_req = 1'b0, int_direct = 1'b0, int_stack = 1'b0;
	logic bypass_wr = 1'b0, bypass_wdata = 1'b0, xm_req = 1'b0, xm_write = 1'b0;
	logic xm_use_data_pointer = 1'b0;
	logic [7:0] int_addr = 8'h00, stack_pointer = 8'hE0, bank_index_register = 8'h00;
	logic [7:0] data_pointer_high = 8'h00, data_pointer_low = 8'h00, xm_wdata = 8'h00;
	logic [7:0] port_zero_sfr = 8'h5C, port_two_sfr = 8'h3E;
	logic sel_lower_q, sel_upper_q, sel_sfr_q, onchip_xram_bypass_q, xm_done_q;
	logic port_zero_oe_q, ale_q, wr_n_q, rd_n_q;
	logic [7:0] int_ram_addr_q, xm_rdata_q, port_zero_bus_q, port_two_upper_address_q;
	logic [7:0] port_zero_in;
	int err_total = 0, n_checks = 0, cyc = 0;
	dmd_decoder i_dut (.mclk, .rst, .int_req, .int_direct, .int_stack, .int_addr,
		.stack_pointer, .sel_lower_q, .sel_upper_q, .sel_sfr_q, .int_ram_addr_q, .bypass_wr,
		.bypass_wdata, .onchip_xram_bypass_q, .xm_req, .xm_write, .xm_use_data_pointer,
		.bank_index_register, .data_pointer_high, .data_pointer_low, .xm_wdata, .xm_done_q,
		.xm_rdata_q, .port_zero_sfr, .port_two_sfr, .port_zero_in, .port_zero_bus_q,
		.port_zero_oe_q, .port_two_upper_address_q, .ale_q, .wr_n_q, .rd_n_q);
	dmd_ext_mem i_mem (.mclk, .ale_q, .wr_n_q, .rd_n_q, .port_zero_bus_q,
		.port_two_upper_address_q, .port_zero_in);
	// Clock
	initial forever #5 mclk = ~mclk;
	task end_sim;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %0t got %h want %h", $time, got, exp);
		end
	endtask
	// Internal access, then look at the selects
	task ia(input logic d, s, input logic [7:0] a, input logic [2:0] e, input logic [7:0] ea);
		@(posedge mclk);
		int_req <= 1'b1;
		int_direct <= d;
		int_stack <= s;
		int_addr <= a;
		@(posedge mclk);
		int_req <= 1'b0;
		@(negedge mclk);
		chk({sel_lower_q, sel_upper_q, sel_sfr_q}, e);
		if (!e[0]) chk(int_ram_addr_q, ea);
	endtask
	// External move, timed to done
	task xm(input logic w, p, input logic [7:0] hi, lo, wd, ex, input int lat);
		int n;
		@(posedge mclk);
		xm_req <= 1'b1;
		xm_write <= w;
		xm_use_data_pointer <= p;
		data_pointer_high <= p ? hi : ~hi; // Unused source differs from the used one
		data_pointer_low <= p ? lo : ~lo;
		bank_index_register <= p ? ~lo : lo;
		xm_wdata <= wd;
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (xm_done_q !== 1'b1 && n < 40);
		chk(n[15:0], lat[15:0]);
		if (!w) chk(xm_rdata_q, ex);
		chk({port_zero_oe_q, port_zero_bus_q, wr_n_q, rd_n_q}, {1'b0, port_zero_sfr, 2'b11});
		if (!p) chk(port_two_upper_address_q, port_two_sfr);
		@(posedge mclk);
		xm_req <= 1'b0;
	endtask
	task bp(input logic v);
		@(posedge mclk);
		bypass_wr <= 1'b1;
		bypass_wdata <= v;
		@(posedge mclk);
		bypass_wr <= 1'b0;
		@(negedge mclk);
		chk(onchip_xram_bypass_q, v);
	endtask
	// Mid-run reset with the bypass bit set
	task rs;
		@(posedge mclk);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(negedge mclk);
		chk({onchip_xram_bypass_q, wr_n_q, rd_n_q, ale_q, port_zero_oe_q}, 5'h0C);
	endtask
	// Hang guard
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			end_sim;
		end
	end
	// Main sequence
	initial begin
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		@(negedge mclk);
		chk({onchip_xram_bypass_q, wr_n_q, rd_n_q, ale_q, port_zero_oe_q}, 5'h0C);
		ia(1'b0, 1'b0, 8'h30, 3'h4, 8'h30);
		ia(1'b1, 1'b0, 8'h30, 3'h4, 8'h30);
		ia(1'b1, 1'b0, 8'hA0, 3'h1, 8'h00);
		ia(1'b0, 1'b0, 8'hA0, 3'h2, 8'hA0);
		ia(1'b1, 1'b1, 8'hA0, 3'h2, 8'hE0);
		xm(1'b1, 1'b0, 8'h00, 8'hA0, 8'h5A, 8'h00, 3);
		xm(1'b1, 1'b1, 8'h02, 8'hFF, 8'h3C, 8'h00, 3);
		xm(1'b1, 1'b1, 8'h12, 8'h34, 8'hC3, 8'h00, 11);
		xm(1'b0, 1'b1, 8'h02, 8'hFF, 8'h00, 8'h3C, 3);
		xm(1'b0, 1'b1, 8'h12, 8'h34, 8'h00, 8'hC3, 11);
		bp(1'b1);
		xm(1'b1, 1'b0, 8'h00, 8'hA0, 8'h77, 8'h00, 11);
		xm(1'b0, 1'b0, 8'h00, 8'hA0, 8'h00, 8'h77, 11);
		xm(1'b1, 1'b1, 8'h00, 8'h10, 8'h99, 8'h00, 11);
		xm(1'b0, 1'b1, 8'h00, 8'h10, 8'h00, 8'h99, 11);
		rs;
		bp(1'b0);
		xm(1'b0, 1'b0, 8'h00, 8'hA0, 8'h00, 8'h5A, 3);
		end_sim;
	end
endmodule // tb_top
`default_nettype wire
